/* hw/stio_pkg.sv */
package stio_pkg;

	// ***********************************************************
	// register map (byte addresses)
	// ***********************************************************
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] FILT_OFS   = 8'h04;
	localparam logic [7:0] STAT_OFS   = 8'h08;
	localparam logic [7:0] ID_OFS     = 8'h0C;

	// ***********************************************************
	// control field positions
	// ***********************************************************
	localparam int CTRL_MODE_LSB   = 0;
	localparam int CTRL_OUTSRC_BIT = 4;
	localparam int CTRL_OUTLVL_BIT = 5;
	localparam int CTRL_CEXP_BIT   = 6;
	localparam int CTRL_RATEEQ_BIT = 7;

	// ***********************************************************
	// status field positions
	// ***********************************************************
	localparam int STAT_FILT_BIT  = 0;
	localparam int STAT_ALIGN_BIT = 1;
	localparam int STAT_STRM_BIT  = 2;
	localparam int STAT_GS_BIT    = 3;
	localparam int STAT_TRIG_LSB  = 8;

	// ***********************************************************
	// reset values and timing
	// ***********************************************************
	localparam logic [15:0] FILT_RST    = 16'h0000;
	localparam logic [31:0] DEV_ID      = 32'h5A5A_0001; // arbitrary
	localparam int          CLK_MHZ     = 100;
	localparam int          US_NS       = 1000;
	localparam int          CLK_NS      = 1000 / CLK_MHZ;
	localparam int          TICKS_PER_US = US_NS / CLK_NS;
	localparam logic [6:0]  TICK_LAST   = 7'(TICKS_PER_US - 1);
	localparam logic [1:0]  RESP_OKAY   = 2'b00;
	localparam logic [1:0]  RESP_SLVERR = 2'b10;

	typedef enum logic [2:0] {
		MODE_DEFAULT,
		MODE_MASTER,
		MODE_SLAVE,
		MODE_GENLOCK,
		MODE_EXT_EVENT,
		MODE_EXT_BURST
	} stio_mode_e;

	typedef struct packed {
		logic       out_src_sync;
		logic       out_level;
		logic       color_exp_prio;
		logic       rates_equal;
		stio_mode_e mode;
	} stio_ctrl_s;

endpackage : stio_pkg

/* hw/stio_glitch_filter.sv */
`timescale 1ns/10ps
module stio_glitch_filter (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        resetn,
	// filter setting in microseconds
	input  wire logic [15:0] filt_us,
	// raw and qualified input
	input  wire logic        din,
	output logic             qual,
	output logic             trig_pulse
);

	// ***********************************************************
	// width counter
	// ***********************************************************
	logic [6:0]  tick_q, tick_d;
	logic [15:0] us_q, us_d;
	logic        qual_q, qual_d;
	logic        pulse_q, pulse_d;
	logic        reached;

	// the qualify compare uses the count reached so far, so the
	// internal trigger lands no earlier than filt_us after rise
	assign reached = (us_q >= filt_us);

	always_comb begin
		tick_d  = tick_q;
		us_d    = us_q;
		qual_d  = qual_q;
		pulse_d = 1'b0;
		if (!din) begin
			tick_d = 7'h00;
			us_d   = 16'h0000;
			qual_d = 1'b0;
		end else if (!qual_q) begin
			if (reached) begin
				qual_d  = 1'b1;
				pulse_d = 1'b1;
			end else if (tick_q == stio_pkg::TICK_LAST) begin
				tick_d = 7'h00;
				us_d   = us_q + 16'h0001;
			end else begin
				tick_d = tick_q + 7'h01;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			tick_q  <= 7'h00;
			us_q    <= 16'h0000;
			qual_q  <= 1'b0;
			pulse_q <= 1'b0;
		end else begin
			tick_q  <= tick_d;
			us_q    <= us_d;
			qual_q  <= qual_d;
			pulse_q <= pulse_d;
		end
	end

	assign qual       = qual_q;
	assign trig_pulse = pulse_q;

endmodule : stio_glitch_filter

/* hw/stio_sync_io.sv */
// Functional notes
// - six sync modes exist; genlock is taken only on global-shutter builds.
// - the opto output depends on source select, frame sync and manual level, not on mode.
// - with source select set, the opto output carries the frame sync pulse.
// - with source select clear, the opto output follows the manual level.
// - an input trigger is accepted only after filter-time continuous activity.
// - the internal trigger comes no earlier than the filter time after rise.
// - the filter always runs; its output serves slave, genlock and event modes.
// - in event modes sensor streams and projector stay on without triggers.
// - after reset the mode is default, with free-running asynchronous streams.
// - frames stay aligned only in default/event, no colour priority, equal rates.
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
module stio_sync_io #(
	parameter bit GLOBAL_SHUTTER = 1'b1
) (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        resetn,
	// axi4-lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read address
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// axi4-lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// pins and sensor side
	input  wire logic        trig_in,
	input  wire logic        frame_sync,
	output logic             opto_out,
	output logic             ext_trig,
	output logic             stream_en,
	output logic             streams_aligned,
	output logic             sync_master
);

	// ***********************************************************
	// helpers
	// ***********************************************************
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == stio_pkg::CTRL_OFS) || (a == stio_pkg::FILT_OFS) ||
			(a == stio_pkg::STAT_OFS) || (a == stio_pkg::ID_OFS);
	endfunction : is_mapped

	function automatic logic filt_mode(input stio_pkg::stio_mode_e m);
		filt_mode = (m == stio_pkg::MODE_SLAVE) ||
			(m == stio_pkg::MODE_GENLOCK) ||
			(m == stio_pkg::MODE_EXT_EVENT) ||
			(m == stio_pkg::MODE_EXT_BURST);
	endfunction : filt_mode

	// ***********************************************************
	// register state
	// ***********************************************************
	stio_pkg::stio_ctrl_s ctrl_q, ctrl_d;
	logic [15:0] filt_q, filt_d;
	logic [7:0]  trig_cnt_q, trig_cnt_d;
	logic        aw_hold_q, aw_hold_d;
	logic [7:0]  aw_addr_q, aw_addr_d;
	logic        w_hold_q, w_hold_d;
	logic [31:0] w_data_q, w_data_d;
	logic [3:0]  w_strb_q, w_strb_d;
	logic        bvalid_q, bvalid_d;
	logic [1:0]  bresp_q, bresp_d;
	logic        rvalid_q, rvalid_d;
	logic [1:0]  rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic        opto_q, opto_d;
	logic        ext_trig_q, ext_trig_d;
	logic        aligned_q, aligned_d;
	logic        awready_q, awready_d;
	logic        wready_q, wready_d;
	logic        arready_q, arready_d;
	logic        master_q, master_d;
	logic        stream_q, stream_d;
	logic        filt_qual;
	logic        filt_pulse;
	logic        do_write;
	logic [31:0] status_w;
	stio_pkg::stio_mode_e new_mode;

	stio_glitch_filter u_filter (
		.core_clk   (core_clk),
		.resetn     (resetn),
		.filt_us    (filt_q),
		.din        (trig_in),
		.qual       (filt_qual),
		.trig_pulse (filt_pulse)
	);

	assign do_write = aw_hold_q && w_hold_q && !bvalid_q;

	always_comb begin
		status_w = 32'h0000_0000;
		status_w[stio_pkg::STAT_FILT_BIT]  = filt_qual;
		status_w[stio_pkg::STAT_ALIGN_BIT] = aligned_q;
		status_w[stio_pkg::STAT_STRM_BIT]  = 1'b1;
		status_w[stio_pkg::STAT_GS_BIT]    = GLOBAL_SHUTTER;
		status_w[stio_pkg::STAT_TRIG_LSB +: 8] = trig_cnt_q;
	end

	// ***********************************************************
	// bus slave and control registers
	// ***********************************************************
	always_comb begin
		ctrl_d     = ctrl_q;
		filt_d     = filt_q;
		aw_hold_d  = aw_hold_q;
		aw_addr_d  = aw_addr_q;
		w_hold_d   = w_hold_q;
		w_data_d   = w_data_q;
		w_strb_d   = w_strb_q;
		bvalid_d   = bvalid_q;
		bresp_d    = bresp_q;
		rvalid_d   = rvalid_q;
		rresp_d    = rresp_q;
		rdata_d    = rdata_q;
		new_mode   = stio_pkg::stio_mode_e'(w_data_q[2:0]);
		if (s_axi_awvalid && !aw_hold_q) begin
			aw_hold_d = 1'b1;
			aw_addr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_hold_q) begin
			w_hold_d = 1'b1;
			w_data_d = s_axi_wdata;
			w_strb_d = s_axi_wstrb;
		end
		if (do_write) begin
			aw_hold_d = 1'b0;
			w_hold_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = stio_pkg::RESP_OKAY;
			case (aw_addr_q)
				stio_pkg::CTRL_OFS: begin
					if (w_strb_q[0]) begin
						// unknown codes and genlock on rolling shutter
						// keep the old mode rather than a bogus one
						if (w_data_q[2:0] <= 3'h5 &&
							(new_mode != stio_pkg::MODE_GENLOCK ||
							GLOBAL_SHUTTER)) begin
							ctrl_d.mode = new_mode;
						end
						ctrl_d.out_src_sync   = w_data_q[stio_pkg::CTRL_OUTSRC_BIT];
						ctrl_d.out_level      = w_data_q[stio_pkg::CTRL_OUTLVL_BIT];
						ctrl_d.color_exp_prio = w_data_q[stio_pkg::CTRL_CEXP_BIT];
						ctrl_d.rates_equal    = w_data_q[stio_pkg::CTRL_RATEEQ_BIT];
					end
				end
				stio_pkg::FILT_OFS: begin
					if (w_strb_q[0]) filt_d[7:0]  = w_data_q[7:0];
					if (w_strb_q[1]) filt_d[15:8] = w_data_q[15:8];
				end
				stio_pkg::STAT_OFS, stio_pkg::ID_OFS: begin
				end
				default: bresp_d = stio_pkg::RESP_SLVERR;
			endcase
		end
		if (bvalid_q && s_axi_bready) bvalid_d = 1'b0;
		if (s_axi_arvalid && !rvalid_q) begin
			rvalid_d = 1'b1;
			rresp_d  = is_mapped(s_axi_araddr) ? stio_pkg::RESP_OKAY :
				stio_pkg::RESP_SLVERR;
			case (s_axi_araddr)
				stio_pkg::CTRL_OFS: rdata_d = {24'h000000, ctrl_q.rates_equal,
					ctrl_q.color_exp_prio, ctrl_q.out_level,
					ctrl_q.out_src_sync, 1'b0, ctrl_q.mode};
				stio_pkg::FILT_OFS: rdata_d = {16'h0000, filt_q};
				stio_pkg::STAT_OFS: rdata_d = status_w;
				stio_pkg::ID_OFS:   rdata_d = stio_pkg::DEV_ID;
				default:            rdata_d = 32'h0000_0000;
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
	end

	// ***********************************************************
	// pin and stream logic
	// ***********************************************************
	always_comb begin
		trig_cnt_d = trig_cnt_q;
		ext_trig_d = 1'b0;
		// output source select wins over mode; level only when clear
		if (ctrl_q.out_src_sync) begin
			opto_d = frame_sync;
		end else begin
			opto_d = ctrl_q.out_level;
		end
		// the next control state decides, so the trigger, aligned and
		// master flags all move on the edge that loads the control word;
		// otherwise a mode change would show a stale flag for a cycle
		if (filt_pulse && filt_mode(ctrl_d.mode)) begin
			ext_trig_d = 1'b1;
			trig_cnt_d = trig_cnt_q + 8'h01;
		end
		aligned_d = (ctrl_d.mode == stio_pkg::MODE_DEFAULT ||
			ctrl_d.mode == stio_pkg::MODE_EXT_EVENT) &&
			!ctrl_d.color_exp_prio && ctrl_d.rates_equal;
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			ctrl_q     <= '{out_src_sync: 1'b0, out_level: 1'b0,
				color_exp_prio: 1'b0, rates_equal: 1'b0,
				mode: stio_pkg::MODE_DEFAULT};
			filt_q     <= stio_pkg::FILT_RST;
			trig_cnt_q <= 8'h00;
			aw_hold_q  <= 1'b0;
			aw_addr_q  <= 8'h00;
			w_hold_q   <= 1'b0;
			w_data_q   <= 32'h0000_0000;
			w_strb_q   <= 4'h0;
			bvalid_q   <= 1'b0;
			bresp_q    <= stio_pkg::RESP_OKAY;
			rvalid_q   <= 1'b0;
			rresp_q    <= stio_pkg::RESP_OKAY;
			rdata_q    <= 32'h0000_0000;
			opto_q     <= 1'b0;
			ext_trig_q <= 1'b0;
			aligned_q  <= 1'b0;
		end else begin
			ctrl_q     <= ctrl_d;
			filt_q     <= filt_d;
			trig_cnt_q <= trig_cnt_d;
			aw_hold_q  <= aw_hold_d;
			aw_addr_q  <= aw_addr_d;
			w_hold_q   <= w_hold_d;
			w_data_q   <= w_data_d;
			w_strb_q   <= w_strb_d;
			bvalid_q   <= bvalid_d;
			bresp_q    <= bresp_d;
			rvalid_q   <= rvalid_d;
			rresp_q    <= rresp_d;
			rdata_q    <= rdata_d;
			opto_q     <= opto_d;
			ext_trig_q <= ext_trig_d;
			aligned_q  <= aligned_d;
		end
	end

	// ***********************************************************
	// output mirrors
	// ***********************************************************
	// ready lines and decoded flags get flops of their own, fed from
	// the next-state values so they never lag the state they mirror
	always_comb begin
		awready_d = !aw_hold_d;
		wready_d  = !w_hold_d;
		arready_d = !rvalid_d;
		master_d  = (ctrl_d.mode == stio_pkg::MODE_MASTER);
		// streams and projector never idle for want of triggers
		stream_d  = 1'b1;
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			arready_q <= 1'b1;
			master_q  <= 1'b0;
			stream_q  <= 1'b1;
		end else begin
			awready_q <= awready_d;
			wready_q  <= wready_d;
			arready_q <= arready_d;
			master_q  <= master_d;
			stream_q  <= stream_d;
		end
	end

	// ***********************************************************
	// outputs
	// ***********************************************************
	// nothing combinational leaves the block: every port is a flop
	assign s_axi_awready   = awready_q;
	assign s_axi_wready    = wready_q;
	assign s_axi_bvalid    = bvalid_q;
	assign s_axi_bresp     = bresp_q;
	assign s_axi_arready   = arready_q;
	assign s_axi_rvalid    = rvalid_q;
	assign s_axi_rresp     = rresp_q;
	assign s_axi_rdata     = rdata_q;
	assign opto_out        = opto_q;
	assign ext_trig        = ext_trig_q;
	assign stream_en       = stream_q;
	assign streams_aligned = aligned_q;
	assign sync_master     = master_q;

endmodule : stio_sync_io

/* tb/stio_sync_io_chk.sv */
`timescale 1ns/10ps
module stio_sync_io_chk (
	// clock and reset
	input wire logic        core_clk,
	input wire logic        resetn,
	// bus handshakes
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// sensor side
	input wire logic        ext_trig,
	input wire logic        stream_en,
	input wire logic        streams_aligned,
	input wire logic        sync_master
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	wr_answer_a: assert property (wr_taken |=> ##[0:2] s_axi_bvalid)
		else $error("write response late");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	rd_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
		else $error("read ready wrong");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("read answer late");
	rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	trig_once_a: assert property (ext_trig |=> !ext_trig)
		else $error("trigger pulse too long");
	trig_mode_a: assert property (ext_trig |-> !sync_master)
		else $error("trigger in master mode");
	align_excl_a: assert property (sync_master |-> !streams_aligned)
		else $error("aligned in master mode");
	stream_on_a: assert property (stream_en)
		else $error("streams stopped");
endmodule : stio_sync_io_chk

bind stio_sync_io stio_sync_io_chk u_chk (.*);

/* tb/stio_trig_src.sv */
`timescale 1ns/10ps
// external trigger source: one clean pulse of width cycles per go
module stio_trig_src (
	// clock
	input wire logic        core_clk,
	// request
	input wire logic        go,
	input wire logic [15:0] width,
	// pin
	output logic            trig_in
);
	logic [15:0] left_q = 16'h0000;
	initial trig_in = 1'b0;
	// plain always: the pin also takes a start value above
	always @(posedge core_clk) begin
		if (go)
			left_q <= width;
		else if (left_q != 16'h0000)
			left_q <= left_q - 16'h0001;
		trig_in <= go || (left_q > 16'h0001);
	end
endmodule : stio_trig_src

/* tb/tb_sync_trigger_io_control.sv */
`timescale 1ns/10ps
module tb_sync_trigger_io_control;
	typedef struct packed {
		logic [7:0] ctrl;
		logic       fs;
		logic       opto;
		logic       algn;
		logic       mst;
	} stio_row_s;
	// control value, frame sync, expected opto, aligned, master
	localparam logic [11:0] ROWS [8] = '{12'hA06, 12'h91D, 12'h920,
		12'h838, 12'hA46, 12'hE44, 12'h95C, 12'h204};
	logic        core_clk, resetn, trig_in, frame_sync, go;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, opto_out, ext_trig;
	logic        stream_en, streams_aligned, sync_master;
	logic [15:0] width;
	stio_row_s   r;
	int          mismatches = 0;
	int          checks = 0;
	int          cyc = 0;

	stio_sync_io dut (
		.core_clk        (core_clk),
		.resetn          (resetn),
		.s_axi_awaddr    (s_axi_awaddr),
		.s_axi_awvalid   (s_axi_awvalid),
		.s_axi_awready   (s_axi_awready),
		.s_axi_wdata     (s_axi_wdata),
		.s_axi_wstrb     (s_axi_wstrb),
		.s_axi_wvalid    (s_axi_wvalid),
		.s_axi_wready    (s_axi_wready),
		.s_axi_bresp     (s_axi_bresp),
		.s_axi_bvalid    (s_axi_bvalid),
		.s_axi_bready    (s_axi_bready),
		.s_axi_araddr    (s_axi_araddr),
		.s_axi_arvalid   (s_axi_arvalid),
		.s_axi_arready   (s_axi_arready),
		.s_axi_rdata     (s_axi_rdata),
		.s_axi_rresp     (s_axi_rresp),
		.s_axi_rvalid    (s_axi_rvalid),
		.s_axi_rready    (s_axi_rready),
		.trig_in         (trig_in),
		.frame_sync      (frame_sync),
		.opto_out        (opto_out),
		.ext_trig        (ext_trig),
		.stream_en       (stream_en),
		.streams_aligned (streams_aligned),
		.sync_master     (sync_master)
	);
	stio_trig_src u_src (.core_clk(core_clk), .go(go), .width(width),
		.trig_in(trig_in));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// ***********************************************************
	// helpers
	// ***********************************************************
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 10000) begin
			mismatches++;
			end_sim();
		end
	end

	task automatic chk(input string n, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (aw || w) begin
			@(posedge core_clk);
			if (aw && s_axi_awready) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge core_clk);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge core_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge core_clk);
	endtask : rd

	// pulse of w cycles; n triggers expected, none before dly cycles
	task automatic pulse(input logic [15:0] w, input int n, dly);
		int cnt = 0;
		int first = 0;
		go <= 1'b1;
		width <= w;
		@(posedge core_clk);
		go <= 1'b0;
		for (int k = 1; k < w + 20; k++) begin
			@(posedge core_clk);
			if (ext_trig === 1'b1) begin
				cnt++;
				if (first == 0)
					first = k;
			end
		end
		chk("trig count", n, cnt);
		if (n > 0)
			chk("trig delay", 1, first > dly);
		$display("test pulse %0d done", w);
	endtask : pulse

	// ***********************************************************
	// sequence
	// ***********************************************************
	initial begin
		resetn = 1'b0;
		{go, width, frame_sync} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
		repeat (12) @(posedge core_clk);
		resetn <= 1'b1;
		foreach (ROWS[i]) begin
			r = ROWS[i];
			wr(stio_pkg::CTRL_OFS, {24'h0, r.ctrl});
			frame_sync <= r.fs;
			repeat (3) @(posedge core_clk);
			chk("opto", r.opto, opto_out);
			chk("aligned", r.algn, streams_aligned);
			chk("master", r.mst, sync_master);
			rd(stio_pkg::CTRL_OFS);
			chk("ctrl", r.ctrl, d);
		end
		$display("test rows done");
		wr(stio_pkg::CTRL_OFS, 32'h27);
		rd(stio_pkg::CTRL_OFS);
		chk("bad mode", 32'h20, d);
		wr(8'h10, 32'h1);
		chk("bresp", stio_pkg::RESP_SLVERR, rsp);
		rd(8'h10);
		chk("rresp", stio_pkg::RESP_SLVERR, rsp);
		chk("rdata", 0, d);
		$display("test bus done");
		wr(stio_pkg::CTRL_OFS, 32'h04);
		wr(stio_pkg::FILT_OFS, 32'h2);
		pulse(16'h012C, 1, 200);
		pulse(16'h0096, 0, 0);
		rd(stio_pkg::STAT_OFS);
		chk("status", 32'h0000_010C, d);
		wr(stio_pkg::CTRL_OFS, 32'h01);
		pulse(16'h012C, 0, 0);
		wr(stio_pkg::CTRL_OFS, 32'h04);
		wr(stio_pkg::FILT_OFS, 32'h0);
		pulse(16'h0005, 1, 0);
		resetn <= 1'b0;
		repeat (12) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		chk("opto rst", 0, opto_out);
		chk("stream", 1, stream_en);
		rd(stio_pkg::CTRL_OFS);
		chk("ctrl rst", 0, d);
		rd(stio_pkg::FILT_OFS);
		chk("filt rst", stio_pkg::FILT_RST, d);
		rd(stio_pkg::ID_OFS);
		chk("id", stio_pkg::DEV_ID, d);
		$display("test reset done");
		end_sim();
	end
endmodule : tb_sync_trigger_io_control
